// file: hdl/atch_pkg.sv
// Constants shared by the asynchronous transmit completion handler
package atch_pkg;
   // ------------------------------------------------------------
   // Event and acknowledge codes
   // ------------------------------------------------------------
   localparam int CODE_W = 5;
   localparam logic [4:0] EVT_NONE = 5'h00;
   localparam logic [4:0] EVT_MISSING_ACK = 5'h03;
   localparam logic [4:0] EVT_TIMEOUT = 5'h0a;
   localparam logic [4:0] EVT_FLUSHED = 5'h0f;
   localparam logic [4:0] ACK_COMPLETE = 5'h11;
   localparam logic [4:0] ACK_PENDING = 5'h12;
   localparam logic [4:0] ACK_BUSY_X = 5'h14;
   localparam logic [4:0] ACK_BUSY_A = 5'h15;
   localparam logic [4:0] ACK_BUSY_B = 5'h16;
   localparam logic [4:0] ACK_TARDY = 5'h1b;
   localparam logic [4:0] ACK_DATA_ERR = 5'h1d;
   localparam logic [4:0] ACK_TYPE_ERR = 5'h1e;
   localparam logic [3:0] WIRE_COMPLETE = 4'h1;
   localparam logic [3:0] WIRE_PENDING = 4'h2;
   localparam logic [3:0] WIRE_BUSY_X = 4'h4;
   localparam logic [3:0] WIRE_BUSY_A = 4'h5;
   localparam logic [3:0] WIRE_BUSY_B = 4'h6;
   localparam logic [3:0] WIRE_TARDY = 4'hb;
   localparam logic [3:0] WIRE_DATA_ERR = 4'hd;
   localparam logic [3:0] WIRE_TYPE_ERR = 4'he;
   // ------------------------------------------------------------
   // Descriptor fields
   // ------------------------------------------------------------
   localparam logic [1:0] INT_ALWAYS = 2'b11;
   localparam logic [1:0] INT_ON_DONE = 2'b01;
   localparam int ADDR_W = 28;
   localparam int Z_W = 4;
   localparam int TS_W = 16;
   // ------------------------------------------------------------
   // Cycle timer fields
   // ------------------------------------------------------------
   localparam int CT_CYC_LSB = 12;
   localparam int CT_CYC_W = 13;
   localparam int CT_SEC_LSB = 25;
   localparam int TS_SEC_W = 3;
   // ------------------------------------------------------------
   // Header layout
   // ------------------------------------------------------------
   localparam int HQ_SRCBUS_BIT = 23;
   localparam int HQ_TCODE_LSB = 4;
   localparam logic [3:0] TCODE_STREAM = 4'ha;
   localparam logic [9:0] BUS_LOCAL_ALL = 10'h3ff;
   localparam int NODE_W = 6;
   // ------------------------------------------------------------
   // Transmit FIFO
   // ------------------------------------------------------------
   localparam int FIFO_W = 33;
   localparam int FIFO_D = 8;
   localparam int STATUS_W = 16;
endpackage

// file: hdl/atch_fifo.sv
// Small synchronous FIFO with flush and registered flags
`timescale 1ns/1ps
module atch_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;
   wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);

   assign out_data_o = mem[rd_ptr];

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready_o <= 1'b0;
         out_valid_o <= 1'b0;
      end else if (flush_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready_o <= 1'b1;
         out_valid_o <= 1'b0;
      end else begin
         wr_ptr <= wr_ptr + AW'(push);
         rd_ptr <= rd_ptr + AW'(pop);
         count <= next_count;
         in_ready_o <= next_count != (AW+1)'(DEPTH);
         out_valid_o <= next_count != '0;
      end
   end
endmodule // atch_fifo

// file: hdl/atch_top.sv
// Asynchronous transmit completion handler with header converter
// Summary of operation
// - Subaction gap with no acknowledge reports event 03h.
// - Destination link or host not operating records acknowledge 1Bh.
// - Destination full records busy codes 14h, 15h or 16h.
// - Oversized block write payload records acknowledge 1Eh.
// - Data CRC or data length error records acknowledge 1Dh.
// - Sent with a response expected records acknowledge 12h.
// - Fully finished with no pending response records acknowledge 11h.
// - Completion writes event field, status and timestamp to descriptor in the same cycle.
// - Abnormal end flushes FIFO, maybe fatal flag, pointer to failing descriptor.
// - Normal end with interrupt field 11b or 01b sets sent flag.
// - Z zero goes idle; otherwise branch address loads next program.
// - Timestamp is seconds low three bits above 13-bit cycle count.
// - Requests store the cycle timer at completion as timestamp.
// - Responses compare their timestamp with the cycle timer for timeout.
// - Ping stores elapsed cycle-timer time until acknowledge arrives.
// - Source bus is 3FFh when select is 0, else node bus.
// - Stream tag, channel and sync pass through unchanged.
// - Headers leaving the FIFO are converted to wire layout.
// - Passed response timestamp limit reports 0Ah, sends no packet.
// - Bus reset during transmission reports event 0Fh.
`timescale 1ns/1ps
module atch_top (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [31:0] bus_cycle_timer_i,
   input wire logic [15:0] node_identifier_reg_i,
   input wire logic hdr_valid_i,
   input wire logic [31:0] hdr_data_i,
   input wire logic hdr_last_i,
   output logic hdr_ready_o,
   output logic tx_valid_o,
   output logic [31:0] tx_data_o,
   output logic tx_last_o,
   input wire logic tx_ready_i,
   input wire logic start_i,
   input wire logic [atch_pkg::CODE_W-1:0] analysis_err_i,
   input wire logic is_response_i,
   input wire logic ping_i,
   input wire logic [atch_pkg::TS_W-1:0] ts_limit_i,
   input wire logic [1:0] int_field_i,
   input wire logic [atch_pkg::Z_W-1:0] z_count_i,
   input wire logic [atch_pkg::ADDR_W-1:0] next_program_pointer_i,
   input wire logic [atch_pkg::ADDR_W-1:0] descriptor_start_field_i,
   input wire logic ack_valid_i,
   input wire logic [3:0] ack_code_i,
   input wire logic gap_i,
   input wire logic bus_reset_i,
   input wire logic clear_fatal_i,
   input wire logic clear_request_i,
   input wire logic clear_response_i,
   output logic launch_o,
   output logic status_wr_o,
   output logic [atch_pkg::STATUS_W-1:0] transfer_status_word_o,
   output logic [atch_pkg::TS_W-1:0] timestamp_o,
   output logic [atch_pkg::CODE_W-1:0] interrupt_event_reg_o,
   output logic [atch_pkg::ADDR_W-1:0] command_pointer_reg_o,
   output logic fatal_error_flag_o,
   output logic request_sent_flag_o,
   output logic response_sent_flag_o,
   output logic flush_o,
   output logic load_next_o,
   output logic idle_o
);
   import atch_pkg::*;

   // ------------------------------------------------------------
   // Completion state machine
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE, ST_SEND, ST_WRITE, ST_ERROR, ST_DONE
   } atch_state_e;

   atch_state_e state;
   logic [CODE_W-1:0] evt;
   logic [TS_W-1:0] stamp;
   logic [TS_W-1:0] launch_ts;
   logic resp;
   logic ping;
   logic [1:0] int_fld;
   logic [Z_W-1:0] z_cnt;
   logic [ADDR_W-1:0] branch;
   logic [ADDR_W-1:0] desc_addr;

   wire [TS_W-1:0] ts_now = {bus_cycle_timer_i[CT_SEC_LSB +: TS_SEC_W],
                             bus_cycle_timer_i[CT_CYC_LSB +: CT_CYC_W]};
   wire [TS_W-1:0] ts_diff = ts_now - ts_limit_i;
   wire ts_passed = !ts_diff[TS_W-1] && (ts_diff != '0);
   wire do_timeout = is_response_i && ts_passed;
   wire [TS_W-1:0] ping_time = ts_now - launch_ts;
   wire [TS_W-1:0] next_stamp = ping ? ping_time : ts_now;
   wire abnormal = !evt[CODE_W-1];
   wire int_hit = (int_fld == INT_ALWAYS) || (int_fld == INT_ON_DONE);
   wire set_req = (state == ST_DONE) && int_hit && !resp;
   wire set_resp = (state == ST_DONE) && int_hit && resp;
   wire set_fatal = (state == ST_ERROR) && (int_fld == INT_ALWAYS);

   logic [CODE_W-1:0] ack_evt;
   always_comb begin
      case (ack_code_i)
         WIRE_COMPLETE: ack_evt = ACK_COMPLETE;
         WIRE_PENDING: ack_evt = ACK_PENDING;
         WIRE_BUSY_X: ack_evt = ACK_BUSY_X;
         WIRE_BUSY_A: ack_evt = ACK_BUSY_A;
         WIRE_BUSY_B: ack_evt = ACK_BUSY_B;
         WIRE_TARDY: ack_evt = ACK_TARDY;
         WIRE_DATA_ERR: ack_evt = ACK_DATA_ERR;
         WIRE_TYPE_ERR: ack_evt = ACK_TYPE_ERR;
         default: ack_evt = {1'b1, ack_code_i};
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= ST_IDLE;
         evt <= EVT_NONE;
         stamp <= '0;
         launch_ts <= '0;
         resp <= 1'b0;
         ping <= 1'b0;
         int_fld <= '0;
         z_cnt <= '0;
         branch <= '0;
         desc_addr <= '0;
         launch_o <= 1'b0;
         status_wr_o <= 1'b0;
         transfer_status_word_o <= '0;
         timestamp_o <= '0;
         interrupt_event_reg_o <= EVT_NONE;
         command_pointer_reg_o <= '0;
         flush_o <= 1'b0;
         load_next_o <= 1'b0;
         idle_o <= 1'b1;
      end else begin
         launch_o <= 1'b0;
         status_wr_o <= 1'b0;
         flush_o <= 1'b0;
         load_next_o <= 1'b0;
         case (state)
            ST_IDLE: begin
               idle_o <= 1'b1;
               if (start_i) begin
                  idle_o <= 1'b0;
                  resp <= is_response_i;
                  ping <= ping_i;
                  int_fld <= int_field_i;
                  z_cnt <= z_count_i;
                  branch <= next_program_pointer_i;
                  desc_addr <= descriptor_start_field_i;
                  stamp <= ts_now;
                  if (analysis_err_i != EVT_NONE) begin
                     evt <= analysis_err_i;
                     state <= ST_WRITE;
                  end else if (do_timeout) begin
                     evt <= EVT_TIMEOUT;
                     state <= ST_WRITE;
                  end else begin
                     launch_o <= 1'b1;
                     launch_ts <= ts_now;
                     state <= ST_SEND;
                  end
               end
            end
            ST_SEND: begin
               if (bus_reset_i) begin
                  evt <= EVT_FLUSHED;
                  stamp <= next_stamp;
                  state <= ST_WRITE;
               end else if (ack_valid_i) begin
                  evt <= ack_evt;
                  stamp <= next_stamp;
                  state <= ST_WRITE;
               end else if (gap_i) begin
                  evt <= EVT_MISSING_ACK;
                  stamp <= next_stamp;
                  state <= ST_WRITE;
               end
            end
            ST_WRITE: begin
               interrupt_event_reg_o <= evt;
               status_wr_o <= 1'b1;
               transfer_status_word_o <= {{(STATUS_W-CODE_W){1'b0}}, evt};
               timestamp_o <= stamp;
               state <= abnormal ? ST_ERROR : ST_DONE;
            end
            ST_ERROR: begin
               flush_o <= 1'b1;
               command_pointer_reg_o <= desc_addr;
               idle_o <= 1'b1;
               state <= ST_IDLE;
            end
            ST_DONE: begin
               if (z_cnt != '0) begin
                  command_pointer_reg_o <= branch;
                  load_next_o <= 1'b1;
               end
               idle_o <= 1'b1;
               state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Sticky completion flags, set beats clear
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fatal_error_flag_o <= 1'b0;
         request_sent_flag_o <= 1'b0;
         response_sent_flag_o <= 1'b0;
      end else begin
         fatal_error_flag_o <= set_fatal || (fatal_error_flag_o && !clear_fatal_i);
         request_sent_flag_o <= set_req || (request_sent_flag_o && !clear_request_i);
         response_sent_flag_o <= set_resp || (response_sent_flag_o && !clear_response_i);
      end
   end

   // ------------------------------------------------------------
   // Transmit FIFO
   // ------------------------------------------------------------
   logic f_valid;
   logic [FIFO_W-1:0] f_word;
   logic f_pop;
   logic f_ready;

   atch_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .flush_i(flush_o),
      .in_valid_i(hdr_valid_i),
      .in_ready_o(f_ready),
      .in_data_i({hdr_last_i, hdr_data_i}),
      .out_valid_o(f_valid),
      .out_ready_i(f_pop),
      .out_data_o(f_word)
   );
   assign hdr_ready_o = f_ready;

   // ------------------------------------------------------------
   // Header converter to wire layout
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      PH_Q0, PH_Q1, PH_SRC, PH_PASS
   } atch_phase_e;

   atch_phase_e phase;
   logic [31:0] hq0;
   logic [31:0] wq1;
   logic wq1_last;
   logic src_sel;

   wire [31:0] f_data = f_word[31:0];
   wire f_last = f_word[FIFO_W-1];
   wire out_free = !tx_valid_o || tx_ready_i;
   wire is_stream = hq0[HQ_TCODE_LSB +: 4] == TCODE_STREAM;
   wire [9:0] src_bus = hq0[HQ_SRCBUS_BIT] ?
                        node_identifier_reg_i[15:NODE_W] : BUS_LOCAL_ALL;
   wire [15:0] src_id = {src_bus, node_identifier_reg_i[NODE_W-1:0]};
   wire [31:0] wire_q0 = {f_data[31:16], hq0[15:0]};
   assign f_pop = f_valid && (phase == PH_Q0 || (out_free && phase != PH_SRC));

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         phase <= PH_Q0;
         hq0 <= '0;
         wq1 <= '0;
         wq1_last <= 1'b0;
         src_sel <= 1'b0;
         tx_valid_o <= 1'b0;
         tx_data_o <= '0;
         tx_last_o <= 1'b0;
      end else if (flush_o) begin
         phase <= PH_Q0;
         tx_valid_o <= 1'b0;
      end else begin
         if (out_free) begin
            tx_valid_o <= 1'b0;
         end
         case (phase)
            PH_Q0: begin
               if (f_valid) begin
                  hq0 <= f_data;
                  phase <= PH_Q1;
               end
            end
            PH_Q1: begin
               if (f_valid && out_free) begin
                  tx_valid_o <= 1'b1;
                  tx_data_o <= wire_q0;
                  tx_last_o <= is_stream && f_last;
                  wq1 <= {src_id, f_data[15:0]};
                  wq1_last <= f_last;
                  src_sel <= hq0[HQ_SRCBUS_BIT];
                  if (is_stream) begin
                     phase <= f_last ? PH_Q0 : PH_PASS;
                  end else begin
                     phase <= PH_SRC;
                  end
               end
            end
            PH_SRC: begin
               if (out_free) begin
                  tx_valid_o <= 1'b1;
                  tx_data_o <= wq1;
                  tx_last_o <= wq1_last;
                  phase <= wq1_last ? PH_Q0 : PH_PASS;
               end
            end
            PH_PASS: begin
               if (f_valid && out_free) begin
                  tx_valid_o <= 1'b1;
                  tx_data_o <= f_data;
                  tx_last_o <= f_last;
                  phase <= f_last ? PH_Q0 : PH_PASS;
               end
            end
            default: phase <= PH_Q0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_missing_ack: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      state == ST_SEND && gap_i && !ack_valid_i && !bus_reset_i
      |=> ##1 interrupt_event_reg_o == EVT_MISSING_ACK && status_wr_o)
      else $error("missing ack not reported as 03h");
   a_ack_pass: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      state == ST_SEND && ack_valid_i && !bus_reset_i && ack_code_i == WIRE_COMPLETE
      |=> ##1 transfer_status_word_o[CODE_W-1:0] == ACK_COMPLETE)
      else $error("ack complete not recorded as 11h");
   a_busy_map: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      state == ST_SEND && ack_valid_i && !bus_reset_i && ack_code_i == WIRE_BUSY_B
      |=> evt == ACK_BUSY_B)
      else $error("busy B not recorded as 16h");
   a_bus_reset: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      state == ST_SEND && bus_reset_i |=> evt == EVT_FLUSHED ##1 status_wr_o)
      else $error("bus reset not reported as 0Fh");
   a_timeout_skip: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      state == ST_IDLE && start_i && analysis_err_i == EVT_NONE && do_timeout
      |=> !launch_o && evt == EVT_TIMEOUT)
      else $error("timed out response was sent");
   a_error_path: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      state == ST_WRITE && abnormal
      |=> ##1 flush_o && command_pointer_reg_o == $past(desc_addr, 2) ##2 !tx_valid_o)
      else $error("abnormal end did not flush and rewind");
   a_fatal_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      state == ST_ERROR && int_fld == INT_ALWAYS |=> fatal_error_flag_o)
      else $error("fatal flag not set");
   a_sent_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      state == ST_DONE && int_fld == INT_ON_DONE
      |=> (resp ? response_sent_flag_o : request_sent_flag_o))
      else $error("sent flag not set");
   a_branch_load: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      state == ST_DONE |=> load_next_o == ($past(z_cnt) != '0) && idle_o)
      else $error("branch handling wrong");
   a_stamp_form: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      state == ST_SEND && ack_valid_i && !bus_reset_i && !ping
      |=> stamp == {$past(bus_cycle_timer_i[27:25]), $past(bus_cycle_timer_i[24:12])})
      else $error("timestamp format wrong");
   a_source_bus: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      phase == PH_SRC && out_free && !flush_o
      |=> tx_data_o[31:22] == (src_sel ? node_identifier_reg_i[15:6] : BUS_LOCAL_ALL))
      else $error("source bus number wrong");
endmodule // atch_top

// file: verif/atch_far_model.sv
// Far-side model: link transmitter readiness and remote node acknowledge
`timescale 1ns/1ps
module atch_far_model (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic launch_i,
   input wire logic stall_i,
   input wire logic [1:0] mode_i,
   input wire logic [3:0] code_i,
   input wire logic [3:0] delay_i,
   output logic tx_ready_o,
   output logic ack_valid_o,
   output logic [3:0] ack_code_o,
   output logic gap_o
);
   logic [3:0] cnt;
   logic busy;
   assign tx_ready_o = !stall_i;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         busy <= 1'b0;
         cnt <= 4'h0;
         ack_valid_o <= 1'b0;
         gap_o <= 1'b0;
         ack_code_o <= 4'h0;
      end else begin
         ack_valid_o <= 1'b0;
         gap_o <= 1'b0;
         ack_code_o <= ~ack_code_o;
         if (launch_i) begin
            busy <= 1'b1;
            cnt <= delay_i;
         end else if (busy && cnt == 4'h0) begin
            busy <= 1'b0;
            ack_valid_o <= (mode_i == 2'd1);
            gap_o <= (mode_i == 2'd2);
            ack_code_o <= code_i;
         end else if (busy) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule // atch_far_model

// file: verif/atch_top_test.sv
// Self-checking bench for the transmit completion handler
`timescale 1ns/1ps
module atch_top_test;
   import atch_pkg::*;
   logic clk_i = 0, reset_n_i = 0, hdr_valid_i = 0, hdr_last_i = 0, start_i = 0, ping_i = 0;
   logic is_response_i = 0, bus_reset_i = 0, stall = 1, launch_o, status_wr_o, flush_o;
   logic clear_fatal_i = 0, clear_request_i = 0, clear_response_i = 0, load_next_o, idle_o;
   logic hdr_ready_o, tx_valid_o, tx_last_o, tx_ready_i, ack_valid_i, gap_i;
   logic fatal_error_flag_o, request_sent_flag_o, response_sent_flag_o;
   logic [31:0] hdr_data_i = 0, tx_data_o, timer = {7'h05, 13'd100, 12'h0};
   logic [15:0] node = {10'h2a5, 6'h13}, ts_limit_i = 16'ha069, tsw, ts;
   logic [1:0] int_field_i = 2'b01, mode = 1;
   logic [3:0] z_count_i = 0, ack_code_i, code = 1, delay = 0;
   logic [4:0] ev;
   logic [27:0] nxt = 28'h0abcde0, desc = 28'h1234560, cptr;
   logic [31:0] got[$], exq[$];
   int fail_count = 0, total_checks = 0, cycles = 0, nl, k;
   logic [3:0] wc[8] = '{WIRE_COMPLETE, WIRE_PENDING, WIRE_BUSY_X, WIRE_BUSY_A,
                         WIRE_BUSY_B, WIRE_TARDY, WIRE_DATA_ERR, WIRE_TYPE_ERR};
   logic [4:0] ac[8] = '{ACK_COMPLETE, ACK_PENDING, ACK_BUSY_X, ACK_BUSY_A,
                         ACK_BUSY_B, ACK_TARDY, ACK_DATA_ERR, ACK_TYPE_ERR};
   always #2 clk_i = ~clk_i;
   atch_top atch_top_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_cycle_timer_i(timer),
      .node_identifier_reg_i(node), .hdr_valid_i(hdr_valid_i), .hdr_data_i(hdr_data_i),
      .hdr_last_i(hdr_last_i), .hdr_ready_o(hdr_ready_o), .tx_valid_o(tx_valid_o),
      .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i),
      .start_i(start_i), .analysis_err_i(5'h00), .is_response_i(is_response_i),
      .ping_i(ping_i), .ts_limit_i(ts_limit_i), .int_field_i(int_field_i),
      .z_count_i(z_count_i), .next_program_pointer_i(nxt), .descriptor_start_field_i(desc),
      .ack_valid_i(ack_valid_i), .ack_code_i(ack_code_i), .gap_i(gap_i),
      .bus_reset_i(bus_reset_i), .clear_fatal_i(clear_fatal_i),
      .clear_request_i(clear_request_i), .clear_response_i(clear_response_i),
      .launch_o(launch_o), .status_wr_o(status_wr_o), .transfer_status_word_o(tsw),
      .timestamp_o(ts), .interrupt_event_reg_o(ev), .command_pointer_reg_o(cptr),
      .fatal_error_flag_o(fatal_error_flag_o), .request_sent_flag_o(request_sent_flag_o),
      .response_sent_flag_o(response_sent_flag_o), .flush_o(flush_o),
      .load_next_o(load_next_o), .idle_o(idle_o));
   atch_far_model atch_far_model_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .launch_i(launch_o), .stall_i(stall), .mode_i(mode), .code_i(code), .delay_i(delay),
      .tx_ready_o(tx_ready_i), .ack_valid_o(ack_valid_i), .ack_code_o(ack_code_i),
      .gap_o(gap_i));
   // ------------------------------------------------------------
   // Checking and closing
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic results();
      $display("checks=%0d errors=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         results();
      end
   end
   // ------------------------------------------------------------
   // Completion handling
   // ------------------------------------------------------------
   task automatic complete(input logic [4:0] e, input logic br, input logic tschk);
      int n;
      @(posedge clk_i) start_i <= 1'b1;
      @(posedge clk_i) start_i <= 1'b0;
      #1 nl = int'(launch_o === 1'b1);
      n = 0;
      do begin
         @(posedge clk_i) bus_reset_i <= br && n == 2;
         #1 n++;
      end while (status_wr_o !== 1'b1 && n < 40);
      chk(tsw, {11'h0, e});
      chk(ev, e);
      if (tschk) chk(ts, {timer[27:25], timer[24:12]});
      @(posedge clk_i) #1 chk(idle_o, 1);
   endtask
   task automatic clear_flags();
      @(posedge clk_i) {clear_fatal_i, clear_request_i, clear_response_i} <= 3'b111;
      @(posedge clk_i) {clear_fatal_i, clear_request_i, clear_response_i} <= 3'b000;
   endtask
   task automatic s_acks();
      for (int i = 0; i < 8; i++) begin
         code <= wc[i];
         delay <= 4'(i);
         is_response_i <= i[0];
         int_field_i <= i[1] ? 2'b11 : 2'b01;
         complete(ac[i], 1'b0, !i[0]);
         chk(i[0] ? response_sent_flag_o : request_sent_flag_o, 1);
         chk(load_next_o, 0);
         chk(nl, 1);
         clear_flags();
      end
      is_response_i <= 1'b0;
   endtask
   task automatic s_gap_branch_reset();
      mode <= 2;
      int_field_i <= 2'b11;
      complete(EVT_MISSING_ACK, 1'b0, 1'b1);
      chk({flush_o, fatal_error_flag_o, cptr}, {2'b11, desc});
      clear_flags();
      mode <= 1;
      code <= WIRE_COMPLETE;
      z_count_i <= 1;
      complete(ACK_COMPLETE, 1'b0, 1'b1);
      chk({load_next_o, flush_o, cptr}, {2'b10, nxt});
      mode <= 0;
      z_count_i <= 0;
      complete(EVT_FLUSHED, 1'b1, 1'b0);
      chk({flush_o, cptr}, {1'b1, desc});
      clear_flags();
   endtask
   task automatic s_timeout();
      is_response_i <= 1'b1;
      ts_limit_i <= 16'ha05f;
      complete(EVT_TIMEOUT, 1'b0, 1'b0);
      chk(nl, 0);
      is_response_i <= 1'b0;
      clear_flags();
   endtask
   task automatic s_ping();
      ping_i <= 1'b1;
      mode <= 1;
      code <= WIRE_COMPLETE;
      delay <= 4'd3;
      fork
         complete(ACK_COMPLETE, 1'b0, 1'b0);
         begin
            repeat (4) @(posedge clk_i);
            timer <= timer + 32'h5000;
         end
      join
      chk(ts, 16'h0005);
      ping_i <= 1'b0;
   endtask
   // ------------------------------------------------------------
   // Header stream
   // ------------------------------------------------------------
   task automatic push(input logic [31:0] d, input logic l);
      int n;
      @(posedge clk_i) {hdr_valid_i, hdr_last_i, hdr_data_i} <= {1'b1, l, d};
      n = 0;
      do begin
         @(posedge clk_i) n++;
      end while (hdr_ready_o !== 1'b1 && n < 40);
      hdr_valid_i <= 1'b0;
   endtask
   task automatic collect(input int cnt);
      int n;
      n = 0;
      while (got.size() < cnt && n < 200) begin
         @(posedge clk_i) n++;
         if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) got.push_back(tx_data_o);
         stall <= n[0];
      end
   endtask
   task automatic s_stream();
      stall <= 1'b1;
      push(32'h00410110, 0);
      push(32'h12345678, 0);
      exq = '{{16'h1234, 16'h0110}, {10'h3ff, 6'h13, 16'h5678}};
      k = 0;
      do begin
         push(k, 0);
         exq.push_back(k);
         k++;
         #1;
      end while (hdr_ready_o === 1'b1 && k < 20);
      chk(k > 5 && k < 10, 1);
      exq.push_back(32'hcafef00d);
      fork
         push(32'hcafef00d, 1);
         collect(k + 3);
      join
      chk(tx_last_o, 1);
      push(32'h00810110, 0);
      push(32'h9abc0042, 1);
      exq.push_back({16'h9abc, 16'h0110});
      exq.push_back({node, 16'h0042});
      collect(k + 5);
      push(32'h00005ba7, 0);
      push(32'h00040000, 0);
      push(32'h11223344, 1);
      exq.push_back({16'h0004, 16'h5ba7});
      exq.push_back(32'h11223344);
      collect(k + 7);
      chk(tx_last_o, 1);
      chk(got.size(), exq.size());
      foreach (exq[j]) chk(got[j], exq[j]);
      stall <= 1'b0;
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      reset_n_i <= 1'b1;
      s_acks();
      s_gap_branch_reset();
      s_timeout();
      s_ping();
      s_stream();
      results();
   end
endmodule // atch_top_test
